// file: logic/ifd_forward_decoder.v
// ISA and DMA memory cycle forward decoder with Avalon-MM registers
`timescale 1ns/1ps
`include "ifd_defs.vh"
module ifd_forward_decoder (
   input  wire        ref_clk,
   input  wire        reset_n,
   // Avalon-MM slave
   input  wire [9:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   // Memory cycle from an ISA master or DMA
   input  wire        cyc_valid,
   input  wire        cyc_is_dma,
   input  wire [31:0] cyc_addr,
   output wire        cyc_ready,
   output reg         fwd_valid,
   output reg         fwd_to_pci,
   output reg  [31:0] fwd_addr,
   output reg         fwd_in_hole
);

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   reg  [7:0]  control_reg;
   reg  [7:0]  rom_enable_reg;
   reg  [7:0]  hole_bottom_reg;
   reg  [7:0]  hole_top_reg;
   reg  [7:0]  boot_cs_reg;
   reg         ack_reg;
   reg  [31:0] rdata_next;
   reg  [7:0]  pending_cycles_reg;

   wire [7:0]  reg_index;
   wire        access;
   wire        wr_lane0;

   assign reg_index       = avs_address[9:2];
   assign access          = (avs_read | avs_write) & ~ack_reg;
   // One wait state: request stalls until the registered answer
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
   assign wr_lane0        = avs_write & access & avs_byteenable[0] &
                            (avs_address[1:0] == 2'b00);

   always @(posedge ref_clk) begin
      if (!reset_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= access;
      end
   end

   always @(posedge ref_clk) begin
      if (!reset_n) begin
         control_reg     <= `IFD_RST_CONTROL;
         rom_enable_reg  <= `IFD_RST_ROM_ENABLE;
         hole_bottom_reg <= `IFD_RST_HOLE_BOTTOM;
         hole_top_reg    <= `IFD_RST_HOLE_TOP;
         boot_cs_reg     <= `IFD_RST_BOOT_CS;
      end else if (wr_lane0) begin
         case (reg_index)
            `IFD_IDX_CONTROL: begin
               control_reg <= avs_writedata[7:0];
            end
            `IFD_IDX_ROM_ENABLE: begin
               rom_enable_reg <= avs_writedata[7:0];
            end
            `IFD_IDX_HOLE_BOTTOM: begin
               hole_bottom_reg <= avs_writedata[7:0];
            end
            `IFD_IDX_HOLE_TOP: begin
               hole_top_reg <= avs_writedata[7:0];
            end
            `IFD_IDX_BOOT_CS: begin
               boot_cs_reg <= avs_writedata[7:0] &
                              (8'h01 << `IFD_BOOT_CS_BIT);
            end
            default: begin
            end
         endcase
      end
   end

   // Read mux; unmapped indices read as zero
   always @* begin
      rdata_next = 32'h00000000;
      case (reg_index)
         `IFD_IDX_CONTROL: begin
            rdata_next[7:0] = control_reg;
         end
         `IFD_IDX_ROM_ENABLE: begin
            rdata_next[7:0] = rom_enable_reg;
         end
         `IFD_IDX_HOLE_BOTTOM: begin
            rdata_next[7:0] = hole_bottom_reg;
         end
         `IFD_IDX_HOLE_TOP: begin
            rdata_next[7:0] = hole_top_reg;
         end
         `IFD_IDX_BOOT_CS: begin
            rdata_next[7:0] = boot_cs_reg;
         end
         8'h4D: begin
            rdata_next[7:0] = pending_cycles_reg;
         end
         default: begin
            rdata_next = 32'h00000000;
         end
      endcase
   end

   always @(posedge ref_clk) begin
      if (!reset_n) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read & access) begin
         avs_readdata <= rdata_next;
      end
   end

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   wire low_hit;
   wire rom_hit;
   wire top_hit;
   wire in_hole;
   wire forward;

   ifd_region_match u_region (
      .addr           (cyc_addr),
      .control        (control_reg),
      .rom_enable     (rom_enable_reg),
      .boot_cs_enable (boot_cs_reg[`IFD_BOOT_CS_BIT]),
      .low_hit        (low_hit),
      .rom_hit        (rom_hit),
      .top_hit        (top_hit)
   );

   ifd_hole_match u_hole (
      .addr        (cyc_addr),
      .hole_bottom (hole_bottom_reg),
      .hole_top    (hole_top_reg),
      .in_hole     (in_hole)
   );

   // ROM blocks forward ISA master cycles only
   assign forward = ~in_hole &
                    (low_hit | top_hit |
                     (rom_hit & ~cyc_is_dma));

   assign cyc_ready = 1'b1;

   // ------------------------------------------------------------
   // Registered decision
   // ------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         fwd_valid   <= 1'b0;
         fwd_to_pci  <= 1'b0;
         fwd_addr    <= 32'h00000000;
         fwd_in_hole <= 1'b0;
      end else begin
         fwd_valid   <= cyc_valid;
         fwd_to_pci  <= cyc_valid & forward;
         fwd_addr    <= cyc_addr;
         fwd_in_hole <= cyc_valid & in_hole;
      end
   end

   // Count of forwarded cycles, wraps, visible to software
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         pending_cycles_reg <= 8'h00;
      end else if (cyc_valid & forward) begin
         pending_cycles_reg <= pending_cycles_reg + 8'h01;
      end
   end

endmodule

// file: logic/ifd_defs.vh
// Offsets, reset values and field positions of the forward decoder
`ifndef IFD_DEFS_VH
`define IFD_DEFS_VH

// ------------------------------------------------------------
// Register offsets (printed index; byte address is four times)
// ------------------------------------------------------------
`define IFD_IDX_CONTROL      8'h48
`define IFD_IDX_ROM_ENABLE   8'h49
`define IFD_IDX_HOLE_BOTTOM  8'h4A
`define IFD_IDX_HOLE_TOP     8'h4B
`define IFD_IDX_BOOT_CS      8'h4C

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define IFD_RST_CONTROL      8'h01
`define IFD_RST_ROM_ENABLE   8'h00
`define IFD_RST_HOLE_BOTTOM  8'h10
`define IFD_RST_HOLE_TOP     8'h0F
`define IFD_RST_BOOT_CS      8'h00

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define IFD_CTL_TOP_HI       7
`define IFD_CTL_TOP_LO       4
`define IFD_CTL_LOW_BIOS     3
`define IFD_CTL_VIDEO        2
`define IFD_CTL_BASE_HI      1
`define IFD_CTL_BASE_LO      0
`define IFD_BOOT_CS_BIT      6

// ------------------------------------------------------------
// Address ranges in 16-Kbyte units (address bits 23:14)
// ------------------------------------------------------------
`define IFD_K16_512K         10'h020
`define IFD_K16_640K         10'h028
`define IFD_K16_768K         10'h030
`define IFD_K16_896K         10'h038
`define IFD_K16_960K         10'h03C
`define IFD_K16_1M           10'h040

`endif

// file: logic/ifd_hole_match.v
// Decoder hole comparison against address lines 23 through 16
`timescale 1ns/1ps
module ifd_hole_match (
   input  wire [31:0] addr,
   input  wire [7:0]  hole_bottom,
   input  wire [7:0]  hole_top,
   output wire        in_hole
);

   wire [7:0] addr_64k;
   wire       upper_zero;
   wire       hole_enabled;

   assign addr_64k     = addr[23:16];
   assign upper_zero   = (addr[31:24] == 8'h00);
   assign hole_enabled = (hole_top >= hole_bottom);
   assign in_hole      = hole_enabled & upper_zero &
                         (addr_64k >= hole_bottom) &
                         (addr_64k <= hole_top);

endmodule

// file: logic/ifd_region_match.v
// Fixed low-memory and ROM block range decode
`timescale 1ns/1ps
`include "ifd_defs.vh"
module ifd_region_match (
   input  wire [31:0] addr,
   input  wire [7:0]  control,
   input  wire [7:0]  rom_enable,
   input  wire        boot_cs_enable,
   output wire        low_hit,
   output wire        rom_hit,
   output wire        top_hit
);

   wire [9:0] k16;
   wire       below_16m;
   wire       in_base;
   wire       in_ext;
   wire       in_video;
   wire       in_rom;
   wire       in_bios;
   wire [2:0] rom_idx;
   wire [3:0] top_mb;

   assign below_16m = (addr[31:24] == 8'h00);
   assign k16       = addr[23:14];
   assign in_base   = below_16m & (k16 < `IFD_K16_512K);
   assign in_ext    = below_16m & (k16 >= `IFD_K16_512K) &
                      (k16 < `IFD_K16_640K);
   assign in_video  = below_16m & (k16 >= `IFD_K16_640K) &
                      (k16 < `IFD_K16_768K);
   assign in_rom    = below_16m & (k16 >= `IFD_K16_768K) &
                      (k16 < `IFD_K16_896K);
   assign in_bios   = below_16m & (k16 >= `IFD_K16_896K) &
                      (k16 < `IFD_K16_960K);

   // Each ROM block is 16 Kbytes from 768K upward
   assign rom_idx = addr[16:14];

   assign low_hit =
      (in_base  & control[`IFD_CTL_BASE_LO]) |
      (in_ext   & control[`IFD_CTL_BASE_HI]) |
      (in_video & control[`IFD_CTL_VIDEO]) |
      (in_bios  & ~boot_cs_enable &
       control[`IFD_CTL_LOW_BIOS]);

   assign rom_hit = in_rom & rom_enable[rom_idx];

   // Region spans 1 Mbyte up to top, value n meaning n+1 Mbytes
   assign top_mb  = control[`IFD_CTL_TOP_HI:`IFD_CTL_TOP_LO];
   assign top_hit = below_16m & (k16 >= `IFD_K16_1M) &
                    (addr[23:20] <= top_mb) &
                    (addr[23:20] != 4'h0);

endmodule

// file: test/ifd_forward_decoder_properties.sv
// Port-level properties of the forward decoder
`timescale 1ns/1ps
module ifd_forward_decoder_properties (
   input wire        ref_clk,
   input wire        reset_n,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_readdata,
   input wire        avs_waitrequest,
   input wire        cyc_valid,
   input wire [31:0] cyc_addr,
   input wire        cyc_ready,
   input wire        fwd_valid,
   input wire        fwd_to_pci,
   input wire [31:0] fwd_addr,
   input wire        fwd_in_hole
);
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!reset_n);
a_wait_first: assert property ($rose(avs_read || avs_write)
   |-> avs_waitrequest) else $error("no wait state on request");
a_wait_single: assert property ((avs_read || avs_write) && avs_waitrequest
   |=> !avs_waitrequest) else $error("more than one wait state");
a_read_upper: assert property (avs_read && !avs_waitrequest
   |-> avs_readdata[31:8] == 24'h0) else $error("read upper bits set");
a_cyc_taken: assert property (cyc_valid |-> cyc_ready)
   else $error("cycle refused");
a_fwd_follows: assert property (cyc_valid
   |=> fwd_valid && fwd_addr == $past(cyc_addr))
   else $error("forward result missing");
a_fwd_idle: assert property (!cyc_valid |=> !fwd_valid)
   else $error("forward result without cycle");
a_hole_blocks: assert property (fwd_in_hole |-> !fwd_to_pci)
   else $error("hole address forwarded");
a_upper_isa: assert property (cyc_valid && cyc_addr[31:24] != 8'h00
   |=> !fwd_in_hole && !fwd_to_pci) else $error("high address decoded");
a_gap_isa: assert property (cyc_valid && cyc_addr[31:16] == 16'h000F
   |=> !fwd_to_pci) else $error("960K to 1M forwarded");
endmodule

// file: test/ifd_cycle_source.sv
// Model of the ISA master and DMA memory cycle source
`timescale 1ns/1ps
module ifd_cycle_source (
   input  wire        ref_clk,
   input  wire        cyc_ready,
   output reg         cyc_valid,
   output reg         cyc_is_dma,
   output reg  [31:0] cyc_addr
);
initial begin
   cyc_valid = 1'b0;
   cyc_is_dma = 1'b0;
   cyc_addr = 32'h0;
end
task send(input [31:0] a, input d);
   begin
      @(posedge ref_clk);
      cyc_valid <= 1'b1;
      cyc_is_dma <= d;
      cyc_addr <= a;
      @(posedge ref_clk);
      while (cyc_ready !== 1'b1) @(posedge ref_clk);
      cyc_valid <= 1'b0;
      cyc_is_dma <= ~d;
      cyc_addr <= ~a;
   end
endtask
endmodule

// file: test/test_ifd_forward_decoder.sv
// Self-checking bench of the forward decoder
`timescale 1ns/1ps
module test_ifd_forward_decoder;
reg         ref_clk = 1'b0;
reg         reset_n = 1'b0;
reg  [9:0]  avs_address = 10'h000;
reg         avs_read = 1'b0;
reg         avs_write = 1'b0;
reg  [31:0] avs_writedata = 32'h0;
reg  [3:0]  avs_byteenable = 4'hF;
wire [31:0] avs_readdata, cyc_addr, fwd_addr;
wire        avs_waitrequest, cyc_valid, cyc_is_dma, cyc_ready;
wire        fwd_valid, fwd_to_pci, fwd_in_hole;
integer     fails = 0;
integer     checks = 0;
integer     i, j;
reg  [31:0] seed = 32'hF4FD;
reg  [31:0] r, a;
reg  [39:0] rv = 40'h000F100001;
reg  [7:0]  ctl, rom, bot, top, boot;
always #10 ref_clk = ~ref_clk;
ifd_forward_decoder dut (.ref_clk(ref_clk), .reset_n(reset_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .cyc_valid(cyc_valid), .cyc_is_dma(cyc_is_dma), .cyc_addr(cyc_addr),
   .cyc_ready(cyc_ready), .fwd_valid(fwd_valid), .fwd_to_pci(fwd_to_pci),
   .fwd_addr(fwd_addr), .fwd_in_hole(fwd_in_hole));
ifd_cycle_source src (.ref_clk(ref_clk), .cyc_ready(cyc_ready),
   .cyc_valid(cyc_valid), .cyc_is_dma(cyc_is_dma), .cyc_addr(cyc_addr));
function [31:0] xs(input [31:0] s);
   reg [31:0] t;
   begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
   end
endfunction
function hole(input [31:0] x);
   hole = x[31:24] == 8'h00 && top >= bot && x[23:16] >= bot
      && x[23:16] <= top;
endfunction
function pci(input [31:0] x, input d);
   reg [9:0] k;
   begin
      k = x[23:14];
      pci = x[31:24] == 8'h00 && !hole(x) && (
         (k < 10'h020 && ctl[0]) || (k >= 10'h040
         && x[23:20] <= ctl[7:4])
         || (k >= 10'h020 && k < 10'h028 && ctl[1])
         || (k >= 10'h028 && k < 10'h030 && ctl[2])
         || (k >= 10'h038 && k < 10'h03C && ctl[3] && !boot[6])
         || (k >= 10'h030 && k < 10'h038 && !d && rom[k[2:0]]));
   end
endfunction
task chk(input [31:0] s, input [31:0] e, input string n);
   begin
      checks = checks + 1;
      if (s !== e) begin
         fails = fails + 1;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   end
endtask
task bus(input w, input [7:0] idx, input [7:0] d, output [31:0] q);
   begin
      @(posedge ref_clk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h0, d};
      avs_read <= !w;
      avs_write <= w;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   end
endtask
task close_out;
   begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   end
endtask
initial begin
   repeat (5) @(posedge ref_clk);
   reset_n <= 1'b1;
   for (i = 0; i < 5; i = i + 1) begin
      bus(0, 8'h48 + i, 8'h00, r);
      chk(r, rv[i*8+:8], "reset value");
   end
   bus(0, 8'hFF, 8'h00, r);
   chk(r, 0, "unmapped read");
   avs_byteenable <= 4'h0;
   bus(1, 8'h48, 8'hFF, r);
   avs_byteenable <= 4'hF;
   bus(0, 8'h48, 8'h00, r);
   chk(r, 32'h01, "masked write");
   for (i = 0; i < 50; i = i + 1) begin
      seed = xs(seed);
      ctl = seed[7:0];
      rom = seed[15:8];
      bot = 8'h10 + seed[23:16] % 8'hF0;
      top = seed[31:24];
      seed = xs(seed);
      boot = seed[7:0] & 8'h40;
      bus(1, 8'h48, ctl, r);
      bus(1, 8'h49, rom, r);
      bus(1, 8'h4A, bot, r);
      bus(1, 8'h4B, top, r);
      bus(1, 8'h4C, seed[7:0], r);
      bus(0, 8'h4A, 8'h00, r);
      chk(r, bot, "hole bottom");
      for (j = 0; j < 12; j = j + 1) begin
         seed = xs(seed);
         case (j % 6)
            0: a = {8'h00, bot, 16'h0000};
            1: a = {8'h00, top, 16'hFFFF};
            2: a = {8'h00, bot, 16'h0000} - 1;
            3: a = {8'h00, top + 8'h01, 16'h0000};
            4: a = {12'h000, seed[19:0]};
            default: a = seed >> (seed[31:30] * 4);
         endcase
         src.send(a, seed[28]);
         @(negedge ref_clk);
         chk(fwd_valid, 1, "valid");
         chk(fwd_addr, a, "address");
         chk(fwd_in_hole, hole(a), "hole");
         chk(fwd_to_pci, pci(a, seed[28]), "to pci");
      end
   end
   close_out;
end
initial begin
   repeat (40000) @(posedge ref_clk);
   fails = fails + 1;
   close_out;
end
endmodule
bind ifd_forward_decoder ifd_forward_decoder_properties chk_i (
   .ref_clk(ref_clk), .reset_n(reset_n), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .cyc_valid(cyc_valid),
   .cyc_addr(cyc_addr), .cyc_ready(cyc_ready), .fwd_valid(fwd_valid),
   .fwd_to_pci(fwd_to_pci), .fwd_addr(fwd_addr), .fwd_in_hole(fwd_in_hole));
